/* File: include/smc_pkg.sv */
/*
 * Package for the safety module mode controller: mode codes, host commands,
 * fault cause codes, flash timing and the status struct.
 * Assumes a single 250 MHz clock domain.
 */
package smc_pkg;

    // ---------------------------------------------------------------
    // Timing and safety machine counts
    // ---------------------------------------------------------------
    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned FLASH_HALF_US  = 250000;
    localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_US * CLK_MHZ;
    localparam int unsigned MACHINES_WIDE  = 8;
    localparam int unsigned MACHINES_NARROW = 4;

    // ---------------------------------------------------------------
    // Operating modes, one-hot
    // ---------------------------------------------------------------
    typedef enum logic [5:0] {
        MODE_UNPROG    = 6'h01,
        MODE_DOWNLOAD  = 6'h02,
        MODE_VERIFY    = 6'h04,
        MODE_OPER      = 6'h08,
        MODE_FAILSAFE  = 6'h10,
        MODE_PWRDOWN   = 6'h20
    } smc_mode_e;

    // ---------------------------------------------------------------
    // Host commands
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE      = 3'h0,
        CMD_DL_BEGIN  = 3'h1,
        CMD_DL_DONE   = 3'h2,
        CMD_DL_FAIL   = 3'h3,
        CMD_TO_OPER   = 3'h4,
        CMD_TO_VERIFY = 3'h5,
        CMD_START     = 3'h6
    } smc_cmd_e;

    // ---------------------------------------------------------------
    // Fail-safe causes
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        CAUSE_NONE = 2'h0,
        CAUSE_USER = 2'h1,
        CAUSE_AUTO = 2'h2
    } smc_cause_e;

    localparam logic       AUTO_START_RST = 1'b1;
    localparam logic [1:0] PCYC_REARM     = 2'h2;

    typedef struct packed {
        smc_mode_e  mode;
        smc_cause_e cause;
        logic       prog_run;
        logic       auto_start;
        logic       fault_stat;
        logic       comm_en;
    } smc_status_s;

endpackage

/* File: verilog/smc_mode_ctrl.sv */
/*
 * Operating-mode controller of a safety I/O module.
 * Assumes the power-on event arrives as power_up (one pulse after each supply
 * cycle), the program store presence and auto start setting are held by
 * non-volatile logic outside, and all inputs are synchronous to sys_clk.
 */
`timescale 1ns/100ps

module smc_mode_ctrl #(
    parameter int unsigned WIDE_VARIANT   = 1,
    parameter int unsigned FLASH_HALF_CYC = smc_pkg::FLASH_HALF_CYC
) (
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    input  wire logic                 clk_en,
    input  wire logic                 power_up,
    input  wire logic                 prog_stored,
    input  wire logic                 auto_start_cfg,
    input  wire logic [2:0]           host_cmd,
    input  wire logic                 host_cmd_vld,
    input  wire logic                 user_fault,
    input  wire logic                 diag_fault,
    input  wire logic                 short_fet_pair,
    input  wire logic                 vsup_overvolt,
    input  wire logic                 int_overvolt,
    input  wire logic [7:0]           fault_in,
    output logic [7:0]                fault_latched,
    output logic [7:0]                sm_enable,
    output logic                      outputs_enable,
    output logic                      supply_status_indicator,
    output logic                      fault_indicator,
    output smc_pkg::smc_status_s      status
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    smc_pkg::smc_mode_e  mode_q, mode_d;
    smc_pkg::smc_cause_e cause_q, cause_d;
    logic       run_q, run_d;
    logic       auto_q, auto_d;
    logic       auto_loaded_q;
    logic [1:0] pcyc_q, pcyc_d;
    logic [7:0] latch_q;
    logic [31:0] flash_cnt_q;
    logic       flash_q;

    wire cmd_ok       = host_cmd_vld && mode_q != smc_pkg::MODE_PWRDOWN;
    wire cmd_dl_begin = cmd_ok && host_cmd == smc_pkg::CMD_DL_BEGIN;
    wire cmd_dl_done  = cmd_ok && host_cmd == smc_pkg::CMD_DL_DONE;
    wire cmd_dl_fail  = cmd_ok && host_cmd == smc_pkg::CMD_DL_FAIL;
    wire cmd_to_oper  = cmd_ok && host_cmd == smc_pkg::CMD_TO_OPER;
    wire cmd_to_ver   = cmd_ok && host_cmd == smc_pkg::CMD_TO_VERIFY;
    wire cmd_start    = cmd_ok && host_cmd == smc_pkg::CMD_START;
    wire pd_trig      = short_fet_pair || vsup_overvolt || int_overvolt;
    wire auto_eff     = auto_loaded_q ? auto_q : auto_start_cfg;
    wire prog_mode    = mode_q == smc_pkg::MODE_VERIFY || mode_q == smc_pkg::MODE_OPER;
    wire [3:0] sm_cnt = (WIDE_VARIANT != 0) ? 4'(smc_pkg::MACHINES_WIDE)
                                            : 4'(smc_pkg::MACHINES_NARROW);

    // ---------------------------------------------------------------
    // Next-state
    // ---------------------------------------------------------------
    always_comb
    begin
        mode_d  = mode_q;
        cause_d = cause_q;
        run_d   = run_q;
        auto_d  = auto_eff;
        pcyc_d  = pcyc_q;
        if (power_up)
        begin
            // Supply cycle: the only way out of power-down, and out of fail-safe other than into power-down
            run_d = 1'b0;
            if (!prog_stored)
            begin
                mode_d = smc_pkg::MODE_UNPROG;
            end
            else
            begin
                mode_d = smc_pkg::MODE_VERIFY;
                // Count supply cycles since the last fail-safe entry, either cause
                if (cause_q != smc_pkg::CAUSE_NONE || pcyc_q != 2'h0)
                begin
                    pcyc_d = pcyc_q + 2'h1;
                end
                if (pcyc_d == smc_pkg::PCYC_REARM)
                begin
                    auto_d  = 1'b1;
                    cause_d = smc_pkg::CAUSE_NONE;
                    pcyc_d  = 2'h0;
                end
                if (cause_q == smc_pkg::CAUSE_AUTO)
                begin
                    cause_d = smc_pkg::CAUSE_NONE;
                end
                // User fault needs explicit start
                run_d = auto_d && cause_d != smc_pkg::CAUSE_USER;
            end
        end
        else if (pd_trig)
        begin
            mode_d = smc_pkg::MODE_PWRDOWN;
            run_d  = 1'b0;
        end
        else if (mode_q == smc_pkg::MODE_PWRDOWN || mode_q == smc_pkg::MODE_FAILSAFE)
        begin
            run_d = 1'b0;
        end
        else if (diag_fault)
        begin
            mode_d  = smc_pkg::MODE_FAILSAFE;
            cause_d = smc_pkg::CAUSE_AUTO;
            pcyc_d  = 2'h0;
            run_d   = 1'b0;
        end
        else if (user_fault && prog_mode && run_q)
        begin
            mode_d  = smc_pkg::MODE_FAILSAFE;
            cause_d = smc_pkg::CAUSE_USER;
            pcyc_d  = 2'h0;
            auto_d  = 1'b0;
            run_d   = 1'b0;
        end
        else
        begin
            case (mode_q)
                smc_pkg::MODE_UNPROG:
                begin
                    if (cmd_dl_begin) mode_d = smc_pkg::MODE_DOWNLOAD;
                end
                smc_pkg::MODE_DOWNLOAD:
                begin
                    if (cmd_dl_done)
                    begin
                        mode_d = smc_pkg::MODE_VERIFY;
                        run_d  = auto_eff;
                    end
                    else if (cmd_dl_fail)
                    begin
                        mode_d = prog_stored ? smc_pkg::MODE_VERIFY : smc_pkg::MODE_UNPROG;
                        run_d  = 1'b0;
                    end
                end
                smc_pkg::MODE_VERIFY:
                begin
                    if (cmd_to_oper)
                    begin
                        mode_d = smc_pkg::MODE_OPER;
                        run_d  = auto_eff;
                    end
                    else if (cmd_dl_begin)
                    begin
                        mode_d = smc_pkg::MODE_DOWNLOAD;
                        run_d  = 1'b0;
                    end
                    else if (cmd_start) run_d = 1'b1;
                end
                smc_pkg::MODE_OPER:
                begin
                    if (cmd_to_ver)
                    begin
                        mode_d = smc_pkg::MODE_VERIFY;
                        run_d  = auto_eff;
                    end
                    else if (cmd_start) run_d = 1'b1;
                end
                default:
                begin
                    mode_d = smc_pkg::MODE_UNPROG;
                    run_d  = 1'b0;
                end
            endcase
            if (prog_mode && cmd_start && cause_q == smc_pkg::CAUSE_USER)
            begin
                cause_d = smc_pkg::CAUSE_NONE;
                pcyc_d  = 2'h0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            mode_q        <= smc_pkg::MODE_UNPROG;
            cause_q       <= smc_pkg::CAUSE_NONE;
            run_q         <= 1'b0;
            auto_q        <= smc_pkg::AUTO_START_RST;
            auto_loaded_q <= 1'b0;
            pcyc_q        <= 2'h0;
        end
        else if (clk_en)
        begin
            mode_q        <= mode_d;
            cause_q       <= cause_d;
            run_q         <= run_d;
            auto_q        <= auto_d;
            auto_loaded_q <= 1'b1;
            pcyc_q        <= pcyc_d;
        end
    end

    // Fault latches ignore mode; only reset clears them
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_latch
            always_ff @(posedge sys_clk)
            begin
                if (!resetn) latch_q[gi] <= 1'b0;
                else if (clk_en && fault_in[gi]) latch_q[gi] <= 1'b1;
            end
        end
    endgenerate

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            flash_cnt_q <= 32'h0;
            flash_q     <= 1'b0;
        end
        else if (clk_en)
        begin
            if (flash_cnt_q >= 32'(FLASH_HALF_CYC - 1))
            begin
                flash_cnt_q <= 32'h0;
                flash_q     <= ~flash_q;
            end
            else flash_cnt_q <= flash_cnt_q + 32'h1;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    wire in_pd = mode_q == smc_pkg::MODE_PWRDOWN;
    wire in_fs = mode_q == smc_pkg::MODE_FAILSAFE;

    assign fault_latched  = latch_q;
    assign sm_enable      = run_q ? 8'((9'h1 << sm_cnt) - 9'h1) : 8'h00;
    assign outputs_enable = run_q && !in_fs && !in_pd;
    assign supply_status_indicator = in_pd ? 1'b0 :
        (mode_q == smc_pkg::MODE_OPER) ? 1'b1 : flash_q;
    assign fault_indicator = in_fs && flash_q;
    // Field order follows smc_status_s: mode, cause, run, auto start, fault, comm
    assign status = {mode_q, cause_q, run_q, auto_eff, in_fs, !in_pd};

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_user_fs;
        clk_en && !power_up && !pd_trig && !diag_fault && user_fault && prog_mode && run_q;
    endsequence

    a_mode_dl_enter: assert property (clk_en && !power_up && !pd_trig && !diag_fault
        && !user_fault && mode_q == smc_pkg::MODE_UNPROG && cmd_dl_begin
        |=> mode_q == smc_pkg::MODE_DOWNLOAD) else $error("download not entered");
    a_mode_dl_done: assert property (clk_en && !power_up && !pd_trig && !diag_fault
        && !user_fault && mode_q == smc_pkg::MODE_DOWNLOAD && cmd_dl_done
        |=> mode_q == smc_pkg::MODE_VERIFY) else $error("verify not entered");
    a_halt_on_switch: assert property (clk_en && !power_up && !pd_trig && !diag_fault
        && !user_fault && mode_q == smc_pkg::MODE_VERIFY && cmd_to_oper && !auto_eff
        |=> mode_q == smc_pkg::MODE_OPER && !run_q) else $error("program not halted");
    a_user_fs_auto: assert property (s_user_fs
        |=> in_fs && !auto_q && !outputs_enable) else $error("user fail-safe wrong");
    a_diag_fs_hold: assert property (in_fs && !power_up && !pd_trig
        |=> in_fs) else $error("fail-safe left without power cycle");
    a_pd_enter: assert property (clk_en && !power_up && pd_trig
        |=> in_pd && !status.comm_en && !outputs_enable) else $error("power-down missed");
    a_led_oper: assert property (mode_q == smc_pkg::MODE_OPER
        |-> supply_status_indicator) else $error("indicator not steady");
    a_latch_keep: assert property (clk_en && $past(clk_en) && $past(latch_q[0])
        |-> latch_q[0]) else $error("latched fault lost");
    a_unprog_boot: assert property (clk_en && power_up && !prog_stored
        |=> mode_q == smc_pkg::MODE_UNPROG) else $error("unprogrammed not entered");

endmodule

/* File: verification/smc_host_model.sv */
/* Host controller model: posts one-cycle mode commands and reads status.
   Assumes its tasks are called just after a rising edge of sys_clk. */
`timescale 1ns/100ps

module smc_host_model (
    input  wire logic                 sys_clk,
    input  wire smc_pkg::smc_status_s status,
    output logic [2:0]                host_cmd,
    output logic                      host_cmd_vld
);
    logic               validated;
    smc_pkg::smc_mode_e seen_mode;

    initial
    begin
        host_cmd = 3'h0;
        host_cmd_vld = 1'b0;
        validated = 1'b0;
    end

    // Mode is only readable while the module still talks
    always @(posedge sys_clk)
        if (status.comm_en) seen_mode <= status.mode;

    task automatic post(input smc_pkg::smc_cmd_e c);
        if (c == smc_pkg::CMD_TO_OPER && !validated) return;
        host_cmd = c;
        host_cmd_vld = 1'b1;
    endtask

    task automatic idle();
        host_cmd_vld = 1'b0;
        host_cmd = 3'h0;
    endtask
endmodule

/* File: verification/smc_mode_ctrl_tb_top.sv */
/* Self-checking bench: a reference model of the modes is compared with
   the design after every taken event. Assumes package, design and host
   model are compiled first. */
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s expected %0h seen %0h", n, e, g); end end

module smc_mode_ctrl_tb_top;
    logic                 sys_clk = 1'b0;
    logic                 resetn, power_up, prog_stored, auto_start_cfg;
    logic                 user_fault, diag_fault, short_fet_pair, vsup_overvolt;
    logic                 int_overvolt, outputs_enable, supply_status_indicator;
    logic                 fault_indicator, host_cmd_vld, m_run, m_auto, fs, clk_en;
    logic [1:0]           m_cause;
    logic [2:0]           host_cmd;
    logic [7:0]           fault_in, fault_latched, sm_enable, m_flt;
    smc_pkg::smc_status_s status;
    smc_pkg::smc_mode_e   m_mode, m_seen;
    int                   errors = 0;
    int                   num_checks = 0;
    int                   pcyc;

    always #2 sys_clk = ~sys_clk;

    smc_mode_ctrl #(.WIDE_VARIANT(1), .FLASH_HALF_CYC(4)) u_dut (
        .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .power_up(power_up),
        .prog_stored(prog_stored), .auto_start_cfg(auto_start_cfg),
        .host_cmd(host_cmd), .host_cmd_vld(host_cmd_vld), .user_fault(user_fault),
        .diag_fault(diag_fault), .short_fet_pair(short_fet_pair),
        .vsup_overvolt(vsup_overvolt), .int_overvolt(int_overvolt),
        .fault_in(fault_in), .fault_latched(fault_latched), .sm_enable(sm_enable),
        .outputs_enable(outputs_enable),
        .supply_status_indicator(supply_status_indicator),
        .fault_indicator(fault_indicator), .status(status));

    smc_host_model u_host (.sys_clk(sys_clk), .status(status),
        .host_cmd(host_cmd), .host_cmd_vld(host_cmd_vld));

    task automatic results();
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check_all();
        `CHK("mode", m_mode, status.mode)
        `CHK("seen", m_seen, u_host.seen_mode)
        `CHK("run", m_run, status.prog_run)
        `CHK("auto", m_auto, status.auto_start)
        `CHK("sm_en", m_run ? 8'hff : 8'h00, sm_enable)
        `CHK("comm", m_mode != smc_pkg::MODE_PWRDOWN, status.comm_en)
        `CHK("latched", m_flt, fault_latched)
        `CHK("out_en", m_run, outputs_enable)
        `CHK("fault_stat", m_mode == smc_pkg::MODE_FAILSAFE, status.fault_stat)
        if (m_mode == smc_pkg::MODE_FAILSAFE)
            `CHK("cause", m_cause, status.cause)
    endtask

    // ---------------------------------------------------------------
    // Reference model: 0 cmd, 1 power, 2 user, 3 diag, 4..6 power-down
    // ---------------------------------------------------------------
    task automatic model(input int k, input logic [2:0] c);
        logic go;
        go = m_mode == smc_pkg::MODE_VERIFY || m_mode == smc_pkg::MODE_OPER;
        if (k == 1)
        begin
            pcyc += int'(fs);
            if (pcyc == 2)
            begin
                m_auto = 1'b1;
                m_cause = 2'h0;
                fs = 1'b0;
            end
            m_mode = prog_stored ? smc_pkg::MODE_VERIFY : smc_pkg::MODE_UNPROG;
            m_run = m_cause == 2'h1 ? 1'b0 : m_auto & prog_stored;
        end
        else if (k >= 4 && k <= 6)
        begin
            m_mode = smc_pkg::MODE_PWRDOWN;
            m_run = 1'b0;
        end
        else if (k == 3 || (k == 2 && m_run && go))
        begin
            m_mode = smc_pkg::MODE_FAILSAFE;
            m_run = 1'b0;
            m_cause = k == 3 ? 2'h2 : 2'h1;
            m_auto = m_auto & (k == 3);
            fs = 1'b1;
            pcyc = 0;
        end
        else if (k == 0)
        begin
            if (m_mode == smc_pkg::MODE_UNPROG && c == 3'h1)
                m_mode = smc_pkg::MODE_DOWNLOAD;
            else if (m_mode == smc_pkg::MODE_DOWNLOAD && c inside {3'h2, 3'h3})
            begin
                m_mode = (c == 3'h2 || prog_stored) ? smc_pkg::MODE_VERIFY
                                                    : smc_pkg::MODE_UNPROG;
                m_run = c == 3'h2 && m_auto;
            end
            else if (go && c == (m_mode == smc_pkg::MODE_VERIFY ? 3'h4 : 3'h5))
            begin
                m_mode = m_mode == smc_pkg::MODE_VERIFY ? smc_pkg::MODE_OPER
                                                        : smc_pkg::MODE_VERIFY;
                m_run = m_auto;
            end
            else if (go && c == 3'h6)
            begin
                m_run = 1'b1;
                // A host start ends the supply-cycle count of a user fail-safe
                if (m_cause == 2'h1)
                    fs = 1'b0;
                m_cause = 2'h0;
            end
        end
    endtask

    // One event taken at the next edge, then compared after it; k 8 holds clk_en low
    task automatic ev(input int k, input logic [2:0] c = 3'h0);
        clk_en = k != 8;
        fault_in = 8'($urandom);
        if (clk_en)
            m_flt |= fault_in;
        // The host reads the mode shown before this edge, unless it went silent
        if (m_mode != smc_pkg::MODE_PWRDOWN)
            m_seen = m_mode;
        {int_overvolt, vsup_overvolt, short_fet_pair, diag_fault, user_fault,
            power_up} = 6'((1 << k) >> 1);
        if (k == 0 || k == 8)
            u_host.post(smc_pkg::smc_cmd_e'(c));
        else
            u_host.idle();
        if (clk_en)
            model(k, c);
        @(posedge sys_clk);
        #1;
        check_all();
    endtask

    task automatic leds();
        int s;
        int f;
        s = 0;
        f = 0;
        repeat (12)
        begin
            ev(7);
            s += int'(supply_status_indicator === 1'b1);
            f += int'(fault_indicator === 1'b1);
        end
        `CHK("sup_led", 1'b1, m_mode == smc_pkg::MODE_OPER ? s == 12 : s % 12 != 0)
        `CHK("flt_led", 1'b1, m_mode == smc_pkg::MODE_FAILSAFE ? f % 12 != 0 : f == 0)
    endtask

    task automatic do_reset(input logic a);
        resetn = 1'b0;
        clk_en = 1'b1;
        auto_start_cfg = a;
        fault_in = 8'h00;
        {int_overvolt, vsup_overvolt, short_fet_pair, diag_fault, user_fault,
            power_up} = 6'h00;
        u_host.idle();
        repeat (4) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        m_mode = smc_pkg::MODE_UNPROG;
        m_run = 1'b0;
        m_auto = a;
        m_cause = 2'h0;
        m_flt = 8'h00;
        fs = 1'b0;
        pcyc = 0;
        ev(7);
    endtask

    // ---------------------------------------------------------------
    // Main sequence; command codes follow smc_cmd_e
    // ---------------------------------------------------------------
    initial
    begin
        void'($urandom(78524));
        prog_stored = 1'b0;
        do_reset(1'b1);
        ev(1);
        ev(0, 3'h1);
        ev(0, 3'h3);
        ev(0, 3'h1);
        prog_stored = 1'b1;
        ev(0, 3'h2);
        leds();
        u_host.validated = 1'b1;
        ev(8, 3'h4);
        ev(0, 3'h4);
        leds();
        ev(0, 3'h2);
        ev(0, 3'h5);
        ev(0, 3'h4);
        ev(1);
        ev(0, 3'h4);
        ev(2);
        leds();
        ev(0, 3'h6);
        ev(1);
        ev(2);
        ev(0, 3'h6);
        ev(0, 3'h4);
        ev(0, 3'h6);
        ev(3);
        ev(0, 3'h5);
        ev(1);
        ev(1);
        ev(3);
        ev(1);
        for (int k = 4; k < 7; k++)
        begin
            ev(k);
            ev(0, 3'h6);
            ev(1);
        end
        repeat (40) ev(0, 3'($urandom_range(6, 4)));
        do_reset(1'b0);
        ev(1);
        ev(0, 3'h6);
        results();
    end

    // The whole sequence takes about 120 cycles; allow many times that
    initial
    begin
        #20000;
        errors++;
        results();
    end
endmodule
